// ==== hdl/uhc_cmd_irq.sv ====
// command status and interrupt status registers of the usb host controller
// assumes event pulses come from logic on clk, so none is synchronised here
//
// Behaviour
// R1: two-bit overrun count in bits 17:16 steps on each overrun, wraps 11 to 00.
// R2: software writing ownership request sets ownership change flag; software clears request.
// R3: bulk pending set by software or controller, cleared when bulk head handling starts.
// R4: control pending set by software or controller, cleared when control head handling starts.
// R5: software sets soft reset bit; hardware clears it when reset completes.
// R6: command bits 15:4 read as zero.
// R7: status flags other than ownership change set only by hardware events, cleared only by software.
// R8: root hub change flag set on any root hub or port status change.
// R9: frame overflow flag set whenever frame count bit 15 toggles.
// R10: unrecoverable error flag is always zero, writes ignored.
// R11: resume detected flag set on downstream resume signalling.
// R12: start of frame flag set when frame management reports a new frame.
// R13: done head flag set after done head stored to shared area.
// R14: scheduling overrun flag set when list processor reports frame overrun.
// R15: interrupt only for enabled flags and only while master enable bit 31 set.
// R16: writing one clears a status flag, writing zero leaves it.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps

module uhc_cmd_irq (
    input wire logic clk, // 20 MHz system clock
    input wire logic rst_b, // asynchronous reset, active low
    input uhc_pkg::uhc_bus_req_t busReq, // register port request
    output logic [31:0] rdData, // read data, cycle after the read strobe
    input uhc_pkg::uhc_evt_t evt, // controller events
    output uhc_pkg::uhc_cmd_t cmd, // command bits to the controller
    output logic irq // level interrupt
);

    uhc_pkg::uhc_state_t stQ;
    uhc_pkg::uhc_state_t stD;
    logic cmdWr;
    logic stWr;
    logic stRd;
    logic maskWr;
    logic [31:0] evSet;
    logic [31:0] clr;

    always_comb begin
        stD = stQ;
        stD.rdData = uhc_pkg::REG_RESET;
        cmdWr = busReq.wr && (busReq.addr == uhc_pkg::CMD_STATUS_ADDR);
        stWr = busReq.wr && (busReq.addr == uhc_pkg::IRQ_STATUS_ADDR);
        maskWr = busReq.wr && (busReq.addr == uhc_pkg::IRQ_MASK_ADDR);
        stRd = busReq.rd && (busReq.addr == uhc_pkg::IRQ_STATUS_ADDR);

        // set beats clear in every pending bit
        stD.cmd.bulkListPending = (stQ.cmd.bulkListPending & ~evt.bulkListStart)
            | evt.bulkListSet | (cmdWr & busReq.wdata[uhc_pkg::CMD_BULK_BIT]); // R3
        stD.cmd.controlListPending = (stQ.cmd.controlListPending & ~evt.controlListStart)
            | evt.controlListSet | (cmdWr & busReq.wdata[uhc_pkg::CMD_CTRL_BIT]); // R4
        stD.cmd.controllerSoftReset = (stQ.cmd.controllerSoftReset & ~evt.softResetDone)
            | (cmdWr & busReq.wdata[uhc_pkg::CMD_RESET_BIT]); // R5
        if (cmdWr) begin
            stD.cmd.ownershipChangeRequest = busReq.wdata[uhc_pkg::CMD_OWN_BIT]; // R2
        end
        if (evt.overrun) begin
            stD.soc = stQ.soc + uhc_pkg::SOC_STEP; // R1
        end

        evSet = uhc_pkg::REG_RESET;
        evSet[uhc_pkg::ST_OWNER_BIT] = cmdWr & busReq.wdata[uhc_pkg::CMD_OWN_BIT]; // R2
        evSet[uhc_pkg::ST_ROOT_HUB_BIT] = evt.rootHubChange; // R8
        evSet[uhc_pkg::ST_FRAME_OVF_BIT] = evt.frameBit15 ^ stQ.frameMsb; // R9
        evSet[uhc_pkg::ST_RESUME_BIT] = evt.resumeSeen; // R11
        evSet[uhc_pkg::ST_SOF_BIT] = evt.frameStart; // R12
        evSet[uhc_pkg::ST_DONE_HEAD_BIT] = evt.doneHeadWritten; // R13
        evSet[uhc_pkg::ST_OVERRUN_BIT] = evt.overrun; // R14
        // a read clears only what it returned; an event in that cycle survives
        clr = (stWr ? busReq.wdata : uhc_pkg::REG_RESET)
            | (stRd ? stQ.status : uhc_pkg::REG_RESET); // R16
        stD.status = ((stQ.status & ~clr) | evSet) & uhc_pkg::STATUS_IMPL; // R7 R10
        stD.frameMsb = evt.frameBit15;

        if (maskWr) begin
            stD.mask = busReq.wdata & uhc_pkg::MASK_IMPL;
        end

        if (busReq.rd) begin
            case (busReq.addr)
                uhc_pkg::CMD_STATUS_ADDR: begin
                    stD.rdData = {14'h0000, stQ.soc, 12'h000, stQ.cmd}; // R6
                end
                uhc_pkg::IRQ_STATUS_ADDR: begin
                    stD.rdData = stQ.status;
                end
                uhc_pkg::IRQ_MASK_ADDR: begin
                    stD.rdData = stQ.mask;
                end
                default: begin
                    stD.rdData = uhc_pkg::REG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stQ <= '0;
        end else begin
            stQ <= stD;
        end
    end

    assign rdData = stQ.rdData;
    assign cmd = stQ.cmd;
    assign irq = stQ.mask[uhc_pkg::MASK_MASTER_BIT] && |(stQ.status & stQ.mask); // R15

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // overrun count: steps on every pulse, even with the flag already up
    overrun_count_a: assert property ( // R1
        evt.overrun
        |=> stQ.soc == $past(stQ.soc) + 2'h1)
        else $error("overrun count did not step");

    count_hold_a: assert property ( // R1
        !evt.overrun
        |=> $stable(stQ.soc))
        else $error("overrun count moved without overrun");

    count_wrap_a: assert property ( // R1
        evt.overrun && stQ.soc == 2'h3
        |=> stQ.soc == 2'h0)
        else $error("overrun count did not wrap");

    count_read_a: assert property ( // R1
        busReq.rd && busReq.addr == uhc_pkg::CMD_STATUS_ADDR
        |=> rdData[17:16] == $past(stQ.soc))
        else $error("overrun count read wrong");

    // ownership request is plain read/write, its flag fires on every one written
    ownership_flag_a: assert property ( // R2
        cmdWr && busReq.wdata[uhc_pkg::CMD_OWN_BIT]
        |=> stQ.status[uhc_pkg::ST_OWNER_BIT] && cmd.ownershipChangeRequest)
        else $error("ownership request did not set flag");

    owner_clear_a: assert property ( // R2
        cmdWr && !busReq.wdata[uhc_pkg::CMD_OWN_BIT]
        |=> !cmd.ownershipChangeRequest)
        else $error("ownership request not cleared by write");

    owner_hold_a: assert property ( // R2
        !cmdWr
        |=> $stable(cmd.ownershipChangeRequest))
        else $error("ownership request moved without write");

    owner_src_a: assert property ( // R2
        $rose(stQ.status[uhc_pkg::ST_OWNER_BIT])
        |-> $past(cmdWr && busReq.wdata[uhc_pkg::CMD_OWN_BIT]))
        else $error("ownership flag set without request");

    // list pending bits: set wins over the start-of-head clear
    bulk_clear_a: assert property ( // R3
        evt.bulkListStart && !evt.bulkListSet && !(cmdWr && busReq.wdata[uhc_pkg::CMD_BULK_BIT])
        |=> !cmd.bulkListPending)
        else $error("bulk pending not cleared");

    bulk_set_sw_a: assert property ( // R3
        cmdWr && busReq.wdata[uhc_pkg::CMD_BULK_BIT]
        |=> cmd.bulkListPending)
        else $error("bulk pending not set by write");

    bulk_set_hw_a: assert property ( // R3
        evt.bulkListSet
        |=> cmd.bulkListPending)
        else $error("bulk pending not set by controller");

    bulk_keep_a: assert property ( // R3
        cmd.bulkListPending && !evt.bulkListStart
        |=> cmd.bulkListPending)
        else $error("bulk pending dropped without list start");

    bulk_src_a: assert property ( // R3
        $rose(cmd.bulkListPending)
        |-> $past(evt.bulkListSet || (cmdWr && busReq.wdata[uhc_pkg::CMD_BULK_BIT])))
        else $error("bulk pending set without source");

    ctrl_clear_a: assert property ( // R4
        evt.controlListStart && !evt.controlListSet && !(cmdWr && busReq.wdata[uhc_pkg::CMD_CTRL_BIT])
        |=> !cmd.controlListPending)
        else $error("control pending not cleared");

    ctrl_set_sw_a: assert property ( // R4
        cmdWr && busReq.wdata[uhc_pkg::CMD_CTRL_BIT]
        |=> cmd.controlListPending)
        else $error("control pending not set by write");

    ctrl_set_hw_a: assert property ( // R4
        evt.controlListSet
        |=> cmd.controlListPending)
        else $error("control pending not set by controller");

    ctrl_keep_a: assert property ( // R4
        cmd.controlListPending && !evt.controlListStart
        |=> cmd.controlListPending)
        else $error("control pending dropped without list start");

    ctrl_src_a: assert property ( // R4
        $rose(cmd.controlListPending)
        |-> $past(evt.controlListSet || (cmdWr && busReq.wdata[uhc_pkg::CMD_CTRL_BIT])))
        else $error("control pending set without source");

    // soft reset: only the done pulse ends it, software cannot take it back
    reset_done_a: assert property ( // R5
        cmd.controllerSoftReset && !evt.softResetDone
        |=> cmd.controllerSoftReset)
        else $error("soft reset bit dropped early");

    reset_set_a: assert property ( // R5
        cmdWr && busReq.wdata[uhc_pkg::CMD_RESET_BIT]
        |=> cmd.controllerSoftReset)
        else $error("soft reset bit not set by write");

    reset_clear_a: assert property ( // R5
        evt.softResetDone && !(cmdWr && busReq.wdata[uhc_pkg::CMD_RESET_BIT])
        |=> !cmd.controllerSoftReset)
        else $error("soft reset bit not cleared on done");

    reset_src_a: assert property ( // R5
        $rose(cmd.controllerSoftReset)
        |-> $past(cmdWr && busReq.wdata[uhc_pkg::CMD_RESET_BIT]))
        else $error("soft reset bit set without write");

    // command word layout on read
    reserved_read_a: assert property ( // R6
        busReq.rd && busReq.addr == uhc_pkg::CMD_STATUS_ADDR
        |=> rdData[15:4] == 12'h000 && rdData[31:18] == 14'h0000)
        else $error("command reserved bits not zero");

    cmd_read_a: assert property ( // R6
        busReq.rd && busReq.addr == uhc_pkg::CMD_STATUS_ADDR
        |=> rdData[3:0] == $past(cmd))
        else $error("command bits read wrong");

    // status flags: hardware sets all but the ownership flag, software clears
    flag_source_a: assert property ( // R7 R9
        $rose(stQ.status[uhc_pkg::ST_FRAME_OVF_BIT])
        |-> $past(evt.frameBit15) != $past(stQ.frameMsb))
        else $error("frame overflow flag set without toggle");

    flag_sticky_a: assert property ( // R7
        stQ.status[uhc_pkg::ST_ROOT_HUB_BIT] && !stWr && !stRd
        |=> stQ.status[uhc_pkg::ST_ROOT_HUB_BIT])
        else $error("root hub flag lost without software clear");

    flags_hold_a: assert property ( // R7
        !stWr && !stRd
        |=> ($past(stQ.status) & ~stQ.status) == uhc_pkg::REG_RESET)
        else $error("status flag lost without software clear");

    status_reserved_a: assert property ( // R7
        (stQ.status & ~uhc_pkg::STATUS_IMPL)
        == uhc_pkg::REG_RESET)
        else $error("reserved status bit set");

    root_hub_a: assert property ( // R8
        evt.rootHubChange
        |=> stQ.status[uhc_pkg::ST_ROOT_HUB_BIT])
        else $error("root hub change not flagged");

    root_hub_src_a: assert property ( // R8
        $rose(stQ.status[uhc_pkg::ST_ROOT_HUB_BIT])
        |-> $past(evt.rootHubChange))
        else $error("root hub flag set without change");

    // frame bit 15 is a level, both directions count
    frame_ovf_a: assert property ( // R9
        evt.frameBit15 != stQ.frameMsb
        |=> stQ.status[uhc_pkg::ST_FRAME_OVF_BIT])
        else $error("frame overflow not flagged");

    frame_track_a: assert property ( // R9
        1'b1
        |=> stQ.frameMsb == $past(evt.frameBit15))
        else $error("frame bit not tracked");

    unrecov_zero_a: assert property ( // R10
        !stQ.status[uhc_pkg::ST_UNRECOV_BIT]
        && !stQ.mask[uhc_pkg::ST_UNRECOV_BIT])
        else $error("unrecoverable error bit set");

    unrecov_write_a: assert property ( // R10
        maskWr && busReq.wdata[uhc_pkg::ST_UNRECOV_BIT]
        |=> !stQ.mask[uhc_pkg::ST_UNRECOV_BIT])
        else $error("unrecoverable error enable took a write");

    // one pair per event flag: the event sets it, nothing else does
    resume_flag_a: assert property ( // R11
        evt.resumeSeen
        |=> stQ.status[uhc_pkg::ST_RESUME_BIT])
        else $error("resume not flagged");

    resume_src_a: assert property ( // R11
        $rose(stQ.status[uhc_pkg::ST_RESUME_BIT])
        |-> $past(evt.resumeSeen))
        else $error("resume flag set without event");

    frame_start_a: assert property ( // R12
        evt.frameStart
        |=> stQ.status[uhc_pkg::ST_SOF_BIT])
        else $error("frame start not flagged");

    frame_start_src_a: assert property ( // R12
        $rose(stQ.status[uhc_pkg::ST_SOF_BIT])
        |-> $past(evt.frameStart))
        else $error("frame start flag set without event");

    done_head_a: assert property ( // R13
        evt.doneHeadWritten
        |=> stQ.status[uhc_pkg::ST_DONE_HEAD_BIT])
        else $error("done head not flagged");

    done_head_src_a: assert property ( // R13
        $rose(stQ.status[uhc_pkg::ST_DONE_HEAD_BIT])
        |-> $past(evt.doneHeadWritten))
        else $error("done head flag set without event");

    overrun_flag_a: assert property ( // R14
        evt.overrun
        |=> stQ.status[uhc_pkg::ST_OVERRUN_BIT])
        else $error("overrun not flagged");

    overrun_src_a: assert property ( // R14
        $rose(stQ.status[uhc_pkg::ST_OVERRUN_BIT])
        |-> $past(evt.overrun))
        else $error("overrun flag set without event");

    // interrupt gating and the mask behind it
    irq_gate_a: assert property ( // R15
        irq
        == (stQ.mask[uhc_pkg::MASK_MASTER_BIT] && (stQ.status & stQ.mask) != 32'h0))
        else $error("interrupt output mismatch");

    irq_master_a: assert property ( // R15
        !stQ.mask[uhc_pkg::MASK_MASTER_BIT]
        |-> !irq)
        else $error("interrupt with master enable off");

    mask_write_a: assert property ( // R15
        maskWr
        |=> stQ.mask == ($past(busReq.wdata) & uhc_pkg::MASK_IMPL))
        else $error("mask write not taken");

    mask_hold_a: assert property ( // R15
        !maskWr
        |=> $stable(stQ.mask))
        else $error("mask moved without write");

    // write one clears, write zero keeps; a same-cycle event still lands
    write_clear_a: assert property ( // R16
        stWr && busReq.wdata[uhc_pkg::ST_SOF_BIT] && !evt.frameStart
        |=> !stQ.status[uhc_pkg::ST_SOF_BIT])
        else $error("write one did not clear flag");

    write_zero_a: assert property ( // R16
        stWr
        |=> ($past(stQ.status) & ~$past(busReq.wdata) & ~stQ.status) == uhc_pkg::REG_RESET)
        else $error("write zero cleared a flag");

    write_one_a: assert property ( // R16
        stWr
        |=> (stQ.status & $past(busReq.wdata) & ~$past(evSet)) == uhc_pkg::REG_RESET)
        else $error("write one left a flag set");

    // a read clears only what it returned
    read_clear_a: assert property ( // R7
        stRd
        |=> (stQ.status & $past(stQ.status) & ~$past(evSet)) == uhc_pkg::REG_RESET)
        else $error("read did not clear returned flags");

endmodule

// ==== hdl/uhc_pkg.sv ====
// constants, field positions and carrier types of the host command/status register pair
// assumes one system clock shared by the bus master and all event sources
package uhc_pkg;

    // byte addresses on the register port
    localparam logic [31:0] CMD_STATUS_ADDR = 32'hfff05008;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hfff0500c;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hfff05010;

    // host_command_status fields
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_CTRL_BIT = 1;
    localparam int CMD_BULK_BIT = 2;
    localparam int CMD_OWN_BIT = 3;

    // host_interrupt_status fields, mask uses the same layout
    localparam int ST_OVERRUN_BIT = 0;
    localparam int ST_DONE_HEAD_BIT = 1;
    localparam int ST_SOF_BIT = 2;
    localparam int ST_RESUME_BIT = 3;
    localparam int ST_UNRECOV_BIT = 4;
    localparam int ST_FRAME_OVF_BIT = 5;
    localparam int ST_ROOT_HUB_BIT = 6;
    localparam int ST_OWNER_BIT = 30;
    localparam int MASK_MASTER_BIT = 31;

    // implemented bits; unrecoverable error stays out of both
    localparam logic [31:0] STATUS_IMPL = 32'h4000006f;
    localparam logic [31:0] MASK_IMPL = 32'hc000006f;

    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [1:0] SOC_RESET = 2'h0;
    localparam logic [1:0] SOC_STEP = 2'h1;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uhc_bus_req_t;

    // all pulses are one cycle, frameBit15 is a level
    typedef struct packed {
        logic softResetDone;
        logic controlListStart;
        logic bulkListStart;
        logic controlListSet;
        logic bulkListSet;
        logic rootHubChange;
        logic frameBit15;
        logic resumeSeen;
        logic frameStart;
        logic doneHeadWritten;
        logic overrun;
    } uhc_evt_t;

    typedef struct packed {
        logic ownershipChangeRequest;
        logic bulkListPending;
        logic controlListPending;
        logic controllerSoftReset;
    } uhc_cmd_t;

    typedef struct packed {
        uhc_cmd_t cmd;
        logic [1:0] soc;
        logic [31:0] status;
        logic [31:0] mask;
        logic frameMsb;
        logic [31:0] rdData;
    } uhc_state_t;

endpackage

// ==== verification/uhc_cmd_irq_tb.sv ====
// self-checking bench for the command and interrupt status register pair
// assumes one clock; bench drives register port and event pulses itself
`timescale 1ns/10ps

module uhc_cmd_irq_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    uhc_pkg::uhc_bus_req_t busReq = '0;
    uhc_pkg::uhc_evt_t evt = '0;
    logic [31:0] rdData;
    uhc_pkg::uhc_cmd_t cmd;
    logic irq;
    int errCount = 0;
    int comparisons = 0;
    int cycles = 0;

    uhc_cmd_irq i_uhc_cmd_irq (.clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
        .evt(evt), .cmd(cmd), .irq(irq));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("Error %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq.wr <= 1'b1;
        busReq.addr <= a;
        busReq.wdata <= d;
        @(posedge clk);
        busReq.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        busReq.rd <= 1'b1;
        busReq.addr <= a;
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk(rdData, exp, "read data");
    endtask

    // one-cycle pulse on the bits of v; the frame bit level is left alone unless v holds it
    task automatic pulse(input logic [10:0] v);
        @(posedge clk);
        evt <= evt | v;
        @(posedge clk);
        evt <= evt & ~v;
        #1;
    endtask

    task automatic t_reset;
        rd(uhc_pkg::CMD_STATUS_ADDR, uhc_pkg::REG_RESET);
        rd(uhc_pkg::IRQ_STATUS_ADDR, uhc_pkg::REG_RESET);
        rd(uhc_pkg::IRQ_MASK_ADDR, uhc_pkg::REG_RESET);
        $display("reset values done");
    endtask

    task automatic t_overrun;
        repeat (3) pulse(11'h001);
        rd(uhc_pkg::CMD_STATUS_ADDR, 32'h00030000);
        pulse(11'h001);
        rd(uhc_pkg::CMD_STATUS_ADDR, 32'h00000000);
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000001);
        $display("overrun count done");
    endtask

    task automatic t_cmd;
        wr(uhc_pkg::CMD_STATUS_ADDR, 32'hffffffff);
        chk(32'(cmd), 32'hf, "command outputs");
        rd(uhc_pkg::CMD_STATUS_ADDR, 32'h0000000f);
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h40000000);
        pulse(11'h400);
        chk(32'(cmd), 32'he, "soft reset end");
        pulse(11'h100);
        chk(32'(cmd), 32'ha, "bulk start");
        pulse(11'h200);
        chk(32'(cmd), 32'h8, "control start");
        wr(uhc_pkg::CMD_STATUS_ADDR, 32'h0);
        chk(32'(cmd), 32'h0, "ownership cleared");
        pulse(11'h080);
        pulse(11'h040);
        chk(32'(cmd), 32'h6, "controller sets pending");
        $display("command bits done");
    endtask

    task automatic t_events;
        for (int i = 0; i < 4; i++) begin
            pulse(11'(1 << i));
            rd(uhc_pkg::IRQ_STATUS_ADDR, 32'(1 << i));
        end
        pulse(11'h020);
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000040);
        pulse(11'h010);
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000020);
        pulse(11'h000);
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000000);
        $display("event flags done");
    endtask

    task automatic t_irq;
        wr(uhc_pkg::IRQ_MASK_ADDR, 32'h80000004);
        pulse(11'h004);
        chk(32'(irq), 32'h1, "irq enabled");
        wr(uhc_pkg::IRQ_MASK_ADDR, 32'h00000004);
        chk(32'(irq), 32'h0, "master off");
        wr(uhc_pkg::IRQ_MASK_ADDR, 32'hffffffff);
        wr(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000000);
        chk(32'(irq), 32'h1, "zero write keeps");
        wr(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000014);
        chk(32'(irq), 32'h0, "one write clears");
        rd(uhc_pkg::IRQ_STATUS_ADDR, 32'h00000000);
        rd(uhc_pkg::IRQ_MASK_ADDR, uhc_pkg::MASK_IMPL);
        rd(32'hfff05020, 32'h00000000);
        $display("interrupt done");
    endtask

    task automatic endSim;
        $display("checks %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, tests need well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount++;
            endSim();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_overrun();
        t_cmd();
        t_events();
        t_irq();
        endSim();
    end
endmodule
